// file: design/mmp_pkg.sv
package mmp_pkg;
   localparam int CNT_W = 16;

   // register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_CNT3 = 8'h08;
   localparam logic [7:0] ADR_CNT4 = 8'h0c;
   localparam logic [7:0] ADR_EDGE = 8'h10;
   localparam logic [7:0] ADR_BUF = 8'h20;
   localparam logic [7:0] ADR_STEP = 8'h04;

   // edge register slots: period/set3, phase1/clear3, phase2/set4, phase3/clear4
   localparam int EDGE_N = 4;
   localparam int E_PER = 0;
   localparam int E_PH1 = 1;
   localparam int E_PH2 = 2;
   localparam int E_PH3 = 3;

   // status bit positions
   localparam int ST_CMPA3 = 0;
   localparam int ST_CMPB3 = 1;
   localparam int ST_WRAP3 = 2;
   localparam int ST_CMPA4 = 3;
   localparam int ST_CMPB4 = 4;
   localparam int ST_WRAP4 = 5;
   localparam int ST_DOWN = 6;
   localparam int FLAG_N = 6;

   // counter clear sources
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A = 2'h1;
   localparam logic [1:0] CLR_B = 2'h2;
   localparam logic [1:0] CLR_SYNC = 2'h3;

   // values after reset, and counter top and zero values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] EDGE_RST = 16'hffff;
   localparam logic [15:0] CNT_TOP = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   typedef enum logic [1:0] {COMBO_NONE, COMBO_RSYNC, COMBO_COMPL, COMBO_RSVD} mmp_combo_e;

   typedef struct packed {
      logic [1:0] psc;
      logic sync;
      logic [1:0] clr4;
      logic [1:0] clr3;
      logic buf_en;
      logic polarity_sel_ch4;
      logic polarity_sel_ch3;
      mmp_combo_e combo;
      logic pwm4;
      logic pwm3;
      logic run4;
      logic run3;
   } mmp_ctrl_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } mmp_bus_s;

   typedef struct packed {
      logic phase3_out_n;
      logic phase3_out;
      logic phase2_out_n;
      logic phase2_out;
      logic phase1_out_n;
      logic phase1_out;
   } mmp_pins_s;
endpackage

// file: design/mmp_tick.sv
`timescale 1ns/10ps
module mmp_tick (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [1:0] i_sel,
   output logic o_tick
);
   typedef struct packed {
      logic [2:0] div;
      logic tick;
   } mmp_tick_s;

   mmp_tick_s s_r;
   mmp_tick_s s_nxt;
   logic [2:0] mask;

   // divide by 1, 2, 4 or 8
   always_comb begin
      mask = 3'((4'h1 << i_sel) - 4'h1);
      s_nxt = s_r;
      s_nxt.div = s_r.div + 3'h1;
      s_nxt.tick = (s_r.div & mask) == mask;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_tick = s_r.tick;
endmodule

// file: design/mmp_timer.sv
// Operation
// - single PWM: pin A goes 1 on set-time match, 0 on clear-time match.
// - single PWM counter clears on either match; sync and free-run allowed.
// - clear on clear-time match with larger set-time gives 0% duty.
// - clear on set-time match with larger clear-time gives 100% duty.
// - reset-sync mode combines channels 3 and 4 into three pairs.
// - reset-sync mode makes six pins outputs and lead counter counts up.
// - phase pins map to channel 3 A/B, channel 4 A/xA, B/xB.
// - software zeroes lead counter first; lag counter runs on its own.
// - reset-sync: lead counter equal to period clears to zero.
// - reset-sync: pairs toggle on own edge match and on clear.
// - complementary mode makes six pins outputs, both counters up/down.
// - complementary pairs never active together.
// - counters turn down on period match, up on lag underflow.
// - matches occur lead, lag, lag, lead each cycle.
// - edge above period gives constant phase output.
// - complementary counters overshoot/undershoot; special flag and transfer rules.
// - complementary: lead compare-A flag only up, lag wrap only underflow.
// - buffered complementary copies buffers at up period match and underflow.
// - equal set and clear times leave the pin unchanged.
// - match acts as the counter leaves the matching value.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module mmp_timer (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire mmp_pkg::mmp_bus_s i_bus,
   output logic [31:0] o_rdata,
   output mmp_pkg::mmp_pins_s o_pins,
   output mmp_pkg::mmp_pins_s o_pins_oe_n
);
   typedef struct packed {
      mmp_pkg::mmp_ctrl_s ctrl;
      logic [15:0] cnt3;
      logic [15:0] cnt4;
      logic [3:0][15:0] edge_r;
      logic [3:0][15:0] buf_r;
      logic [5:0] flags;
      logic down;
      logic under;
      logic [2:0] ph;
      mmp_pkg::mmp_pins_s pins;
      mmp_pkg::mmp_pins_s oe_n;
      logic [31:0] rdata;
   } mmp_state_s;

   mmp_state_s s_r;
   mmp_state_s s_nxt;
   logic tick;
   logic t3;
   logic t4;
   logic m_a3;
   logic m_b3;
   logic m_a4;
   logic m_b4;
   logic rs2;
   logic rs3;
   logic uf;
   logic is_none;
   logic is_rsync;
   logic is_compl;

   // compare fires on a counter tick while equal
   function automatic logic mmp_hit(input logic en, input logic [15:0] c, input logic [15:0] r);
      return en && (c == r);
   endfunction

   function automatic logic mmp_clr(input logic [1:0] sel, input logic a, input logic b);
      return (sel == mmp_pkg::CLR_A && a) || (sel == mmp_pkg::CLR_B && b);
   endfunction

   function automatic logic [1:0] mmp_pair(input logic pol, input logic p, input logic q);
      return {q ~^ pol, p ~^ pol};
   endfunction

   mmp_tick u_tick (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_sel(s_r.ctrl.psc),
      .o_tick(tick)
   );

   assign is_rsync = s_r.ctrl.combo == mmp_pkg::COMBO_RSYNC;
   assign is_compl = s_r.ctrl.combo == mmp_pkg::COMBO_COMPL;
   assign is_none = !is_rsync && !is_compl;
   assign t3 = tick && s_r.ctrl.run3;
   assign t4 = tick && (is_compl ? s_r.ctrl.run3 : s_r.ctrl.run4);
   assign m_a3 = mmp_hit(t3, s_r.cnt3, s_r.edge_r[mmp_pkg::E_PER]);
   assign m_b3 = mmp_hit(t3, s_r.cnt3, s_r.edge_r[mmp_pkg::E_PH1]);
   assign m_a4 = mmp_hit(t4, s_r.cnt4, s_r.edge_r[mmp_pkg::E_PH2]);
   assign m_b4 = mmp_hit(t4, s_r.cnt4, s_r.edge_r[mmp_pkg::E_PH3]);
   assign rs2 = mmp_hit(t3, s_r.cnt3, s_r.edge_r[mmp_pkg::E_PH2]);
   assign rs3 = mmp_hit(t3, s_r.cnt3, s_r.edge_r[mmp_pkg::E_PH3]);
   assign uf = is_compl && t3 && s_r.down && s_r.cnt4 == mmp_pkg::CNT_ZERO;

   always_comb begin
      logic c3;
      logic c4;
      logic [5:0] set_f;
      logic [2:0] pos;
      logic [2:0] neg;
      logic [1:0] pr;
      c3 = 1'b0;
      c4 = 1'b0;
      set_f = '0;
      pos = '0;
      neg = '0;
      pr = '0;
      s_nxt = s_r;
      s_nxt.rdata = '0;
      if (i_bus.wr && i_bus.addr == mmp_pkg::ADR_STAT) begin
         s_nxt.flags = s_r.flags & ~i_bus.wdata[5:0];
      end
      unique case (s_r.ctrl.combo)
         mmp_pkg::COMBO_NONE, mmp_pkg::COMBO_RSVD: begin
            c3 = mmp_clr(s_r.ctrl.clr3, m_a3, m_b3);
            c4 = mmp_clr(s_r.ctrl.clr4, m_a4, m_b4);
            if (s_r.ctrl.sync) begin
               c3 = c3 || (s_r.ctrl.clr3 == mmp_pkg::CLR_SYNC && t3 && c4);
               c4 = c4 || (s_r.ctrl.clr4 == mmp_pkg::CLR_SYNC && t4 && c3);
            end
            if (t3) begin
               s_nxt.cnt3 = c3 ? mmp_pkg::CNT_ZERO : s_r.cnt3 + 16'h0001;
            end
            if (t4) begin
               s_nxt.cnt4 = c4 ? mmp_pkg::CNT_ZERO : s_r.cnt4 + 16'h0001;
            end
            set_f[mmp_pkg::ST_WRAP3] = t3 && !c3 && s_r.cnt3 == mmp_pkg::CNT_TOP;
            set_f[mmp_pkg::ST_WRAP4] = t4 && !c4 && s_r.cnt4 == mmp_pkg::CNT_TOP;
            set_f[mmp_pkg::ST_CMPA3] = m_a3;
            set_f[mmp_pkg::ST_CMPA4] = m_a4;
            // set on A, clear on B, equal holds
            if (s_r.ctrl.pwm3 && m_a3 && !m_b3) begin
               s_nxt.pins.phase1_out = 1'b1;
            end
            if (s_r.ctrl.pwm3 && m_b3 && !m_a3) begin
               s_nxt.pins.phase1_out = 1'b0;
            end
            if (s_r.ctrl.pwm4 && m_a4 && !m_b4) begin
               s_nxt.pins.phase2_out = 1'b1;
            end
            if (s_r.ctrl.pwm4 && m_b4 && !m_a4) begin
               s_nxt.pins.phase2_out = 1'b0;
            end
            set_f[mmp_pkg::ST_CMPB3] = m_b3;
            set_f[mmp_pkg::ST_CMPB4] = m_b4;
         end
         mmp_pkg::COMBO_RSYNC: begin
            if (t3) begin
               s_nxt.cnt3 = m_a3 ? mmp_pkg::CNT_ZERO : s_r.cnt3 + 16'h0001;
            end
            if (t4) begin
               s_nxt.cnt4 = s_r.cnt4 + 16'h0001;
            end
            set_f[mmp_pkg::ST_WRAP4] = t4 && s_r.cnt4 == mmp_pkg::CNT_TOP;
            set_f[mmp_pkg::ST_CMPA3] = m_a3;
            set_f[mmp_pkg::ST_CMPB3] = m_b3;
            s_nxt.ph = s_r.ph ^ {rs3 ^ m_a3, rs2 ^ m_a3, m_b3 ^ m_a3};
            if (s_r.ctrl.buf_en && m_a3) begin
               s_nxt.edge_r = s_r.buf_r;
            end
         end
         mmp_pkg::COMBO_COMPL: begin
            // count on past the turn point, then reverse
            if (t3 && !s_r.down) begin
               s_nxt.cnt3 = s_r.cnt3 + 16'h0001;
               s_nxt.cnt4 = s_r.cnt4 + 16'h0001;
               s_nxt.under = 1'b0;
            end else if (t3) begin
               s_nxt.cnt3 = s_r.cnt3 - 16'h0001;
               s_nxt.cnt4 = s_r.cnt4 - 16'h0001;
            end
            if (m_a3 && !s_r.down) begin
               s_nxt.down = 1'b1;
            end
            if (uf) begin
               s_nxt.down = 1'b0;
               s_nxt.under = 1'b1;
            end
            set_f[mmp_pkg::ST_CMPA3] = m_a3 && !s_r.down;
            set_f[mmp_pkg::ST_WRAP4] = uf;
            if (s_r.ctrl.buf_en && ((m_a3 && !s_r.down) || uf)) begin
               s_nxt.edge_r = s_r.buf_r;
            end
         end
      endcase
      s_nxt.flags = s_nxt.flags | set_f;
      // complementary: lag counter drives primary, lead drives partner; reset-sync pairs follow ph
      for (int k = 0; k < 3; k++) begin
         pos[k] = !s_nxt.under && s_nxt.cnt4 >= s_nxt.edge_r[k + 1];
         neg[k] = s_nxt.cnt3 < s_nxt.edge_r[k + 1];
      end
      if (s_nxt.ctrl.combo == mmp_pkg::COMBO_COMPL) begin
         pr = mmp_pair(s_r.ctrl.polarity_sel_ch3, pos[0], neg[0]);
         {s_nxt.pins.phase1_out_n, s_nxt.pins.phase1_out} = pr;
         pr = mmp_pair(s_r.ctrl.polarity_sel_ch4, pos[1], neg[1]);
         {s_nxt.pins.phase2_out_n, s_nxt.pins.phase2_out} = pr;
         pr = mmp_pair(s_r.ctrl.polarity_sel_ch4, pos[2], neg[2]);
         {s_nxt.pins.phase3_out_n, s_nxt.pins.phase3_out} = pr;
      end else if (s_nxt.ctrl.combo == mmp_pkg::COMBO_RSYNC) begin
         pr = mmp_pair(s_r.ctrl.polarity_sel_ch3, s_nxt.ph[0], !s_nxt.ph[0]);
         {s_nxt.pins.phase1_out_n, s_nxt.pins.phase1_out} = pr;
         pr = mmp_pair(s_r.ctrl.polarity_sel_ch4, s_nxt.ph[1], !s_nxt.ph[1]);
         {s_nxt.pins.phase2_out_n, s_nxt.pins.phase2_out} = pr;
         pr = mmp_pair(s_r.ctrl.polarity_sel_ch4, s_nxt.ph[2], !s_nxt.ph[2]);
         {s_nxt.pins.phase3_out_n, s_nxt.pins.phase3_out} = pr;
      end
      // software writes win over counting
      if (i_bus.wr) begin
         if (i_bus.addr == mmp_pkg::ADR_CTRL) begin
            s_nxt.ctrl = i_bus.wdata[15:0];
         end
         if (i_bus.addr == mmp_pkg::ADR_CNT3) begin
            s_nxt.cnt3 = i_bus.wdata[15:0];
            if (s_r.ctrl.sync) begin
               s_nxt.cnt4 = i_bus.wdata[15:0];
               s_nxt.under = 1'b0;
            end
         end
         if (i_bus.addr == mmp_pkg::ADR_CNT4) begin
            s_nxt.cnt4 = i_bus.wdata[15:0];
            s_nxt.under = 1'b0;
            if (s_r.ctrl.sync) begin
               s_nxt.cnt3 = i_bus.wdata[15:0];
            end
         end
         for (int k = 0; k < mmp_pkg::EDGE_N; k++) begin
            if (i_bus.addr == mmp_pkg::ADR_EDGE + 8'(k * 4)) begin
               s_nxt.edge_r[k] = i_bus.wdata[15:0];
            end
            if (i_bus.addr == mmp_pkg::ADR_BUF + 8'(k * 4)) begin
               s_nxt.buf_r[k] = i_bus.wdata[15:0];
            end
         end
      end
      // combined modes drive all six pins
      s_nxt.oe_n = '1;
      if (s_nxt.ctrl.combo == mmp_pkg::COMBO_RSYNC || s_nxt.ctrl.combo == mmp_pkg::COMBO_COMPL) begin
         s_nxt.oe_n = '0;
      end else begin
         s_nxt.oe_n.phase1_out = !s_nxt.ctrl.pwm3;
         s_nxt.oe_n.phase2_out = !s_nxt.ctrl.pwm4;
      end
      if (!s_r.down || s_nxt.ctrl.combo != mmp_pkg::COMBO_COMPL) begin
         s_nxt.down = s_nxt.ctrl.combo == mmp_pkg::COMBO_COMPL ? s_nxt.down : 1'b0;
      end
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            mmp_pkg::ADR_CTRL: s_nxt.rdata = {16'h0000, s_r.ctrl};
            mmp_pkg::ADR_STAT: s_nxt.rdata = {25'h0000000, s_r.down, s_r.flags};
            mmp_pkg::ADR_CNT3: s_nxt.rdata = {16'h0000, s_r.cnt3};
            mmp_pkg::ADR_CNT4: s_nxt.rdata = {16'h0000, s_r.cnt4};
            default: begin
               for (int k = 0; k < mmp_pkg::EDGE_N; k++) begin
                  if (i_bus.addr == mmp_pkg::ADR_EDGE + 8'(k * 4)) begin
                     s_nxt.rdata = {16'h0000, s_r.edge_r[k]};
                  end
                  if (i_bus.addr == mmp_pkg::ADR_BUF + 8'(k * 4)) begin
                     s_nxt.rdata = {16'h0000, s_r.buf_r[k]};
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s_r.ctrl <= mmp_pkg::CTRL_RST;
         s_r.cnt3 <= mmp_pkg::CNT_RST;
         s_r.cnt4 <= mmp_pkg::CNT_RST;
         s_r.edge_r <= {4{mmp_pkg::EDGE_RST}};
         s_r.buf_r <= {4{mmp_pkg::EDGE_RST}};
         s_r.flags <= '0;
         s_r.down <= 1'b0;
         s_r.under <= 1'b0;
         s_r.ph <= '0;
         s_r.pins <= '0;
         s_r.oe_n <= '1;
         s_r.rdata <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rdata = s_r.rdata;
   assign o_pins = s_r.pins;
   assign o_pins_oe_n = s_r.oe_n;

   // checks

   a_pwm_sets_high: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_none && s_r.ctrl.pwm3 && m_a3 && !m_b3 && !i_bus.wr |=> o_pins.phase1_out)
      else $error("pin A not set on set-time match");
   a_pwm_clears_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_none && s_r.ctrl.pwm3 && m_b3 && !m_a3 && !i_bus.wr |=> !o_pins.phase1_out)
      else $error("pin A not cleared on clear-time match");
   a_pwm_equal_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_none && m_a3 && m_b3 && !i_bus.wr |=> $stable(o_pins.phase1_out))
      else $error("pin moved on equal match");
   a_rsync_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_rsync && m_a3 && !i_bus.wr |=> s_r.cnt3 == mmp_pkg::CNT_ZERO ##1 s_r.cnt3 <= 16'h0001)
      else $error("lead counter not restarted from zero");
   a_rsync_toggle: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_rsync && m_a3 && !m_b3 && !i_bus.wr |=> o_pins.phase1_out != $past(o_pins.phase1_out))
      else $error("phase pair did not toggle on clear");
   a_compl_nonoverlap: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_compl && $past(is_compl) |-> !(o_pins.phase1_out == s_r.ctrl.polarity_sel_ch3
      && o_pins.phase1_out_n == s_r.ctrl.polarity_sel_ch3))
      else $error("phase 1 pair active together");
   a_compl_turn: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_compl && !s_r.down && m_a3 && !i_bus.wr |=> s_r.down ##0 s_r.cnt3 == $past(s_r.cnt3) + 16'h0001)
      else $error("no overshoot turn at period match");
   a_compl_flag_up: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_compl && s_r.down && !i_bus.wr |=> !$rose(s_r.flags[mmp_pkg::ST_CMPA3]))
      else $error("compare flag set while counting down");
   a_compl_buf_xfer: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_compl && s_r.ctrl.buf_en && uf && !i_bus.wr |=> s_r.edge_r == $past(s_r.buf_r) && !s_r.down)
      else $error("buffers not moved at underflow");
   a_combo_pins_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !is_none && !i_bus.wr |=> o_pins_oe_n == '0)
      else $error("combined mode pins not driven");
   a_pwm4_sets_high: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_none && s_r.ctrl.pwm4 && m_a4 && !m_b4 && !i_bus.wr |=> o_pins.phase2_out)
      else $error("channel 4 pin not set on set-time match");
   a_rsync_count_up: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_rsync && t3 && !m_a3 && !i_bus.wr |=> s_r.cnt3 == $past(s_r.cnt3) + 16'h0001)
      else $error("lead counter not counting up");
   a_compl_undershoot: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_compl && uf && !i_bus.wr |=> !s_r.down && s_r.cnt4 == mmp_pkg::CNT_TOP)
      else $error("lag counter did not undershoot and turn up");
   a_wrap_flag_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
      is_compl && uf |=> s_r.flags[mmp_pkg::ST_WRAP4])
      else $error("wrap flag not set on underflow");

   c_single_pwm: cover property (@(posedge i_clk) disable iff (!i_resetn)
      is_none && s_r.ctrl.pwm3 && m_a3 ##[1:200] m_b3);
   c_rsync_wrap: cover property (@(posedge i_clk) disable iff (!i_resetn) is_rsync && m_a3);
   c_pwm4_match: cover property (@(posedge i_clk) disable iff (!i_resetn)
      is_none && s_r.ctrl.pwm4 && m_a4);
   c_compl_cycle: cover property (@(posedge i_clk) disable iff (!i_resetn)
      is_compl && m_a3 && !s_r.down ##[1:500] uf);
endmodule

// file: tb/mmp_load.sv
`timescale 1ns/10ps
// load on the six phase pins: pull-down when a pin is released
module mmp_load (
   input wire logic i_clk,
   input wire logic i_clr,
   input wire mmp_pkg::mmp_pins_s i_pins,
   input wire mmp_pkg::mmp_pins_s i_pins_oe_n,
   output logic [5:0] o_level,
   output logic [5:0][15:0] o_hi,
   output logic [5:0][15:0] o_tog,
   output logic [15:0] o_overlap
);
   logic [5:0] prev_r;

   // released pin reads low through the pull-down
   assign o_level = ~i_pins_oe_n & i_pins;

   always_ff @(posedge i_clk) begin
      prev_r <= o_level;
      if (i_clr) begin
         o_hi <= '0;
         o_tog <= '0;
         o_overlap <= '0;
      end else begin
         for (int k = 0; k < 6; k++) begin
            o_hi[k] <= o_hi[k] + 16'(o_level[k]);
            o_tog[k] <= o_tog[k] + 16'(o_level[k] != prev_r[k]);
         end
         // both switches of one leg on at once
         if ((o_level[0] & o_level[1]) | (o_level[2] & o_level[3]) |
               (o_level[4] & o_level[5])) begin
            o_overlap <= o_overlap + 16'h0001;
         end
      end
   end
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic clr = 1'b0;
   mmp_pkg::mmp_bus_s bus = '0;
   logic [31:0] o_rdata;
   mmp_pkg::mmp_pins_s o_pins;
   mmp_pkg::mmp_pins_s o_pins_oe_n;
   logic [5:0] level;
   logic [5:0][15:0] hi;
   logic [5:0][15:0] tog;
   logic [15:0] overlap;
   logic [31:0] d;
   logic [31:0] mx;
   logic up;
   logic dn;
   int failures = 0;
   int n_checks = 0;

   always #2 i_clk = ~i_clk;

   mmp_timer uut (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_bus(bus),
      .o_rdata(o_rdata),
      .o_pins(o_pins),
      .o_pins_oe_n(o_pins_oe_n)
   );

   mmp_load load (
      .i_clk(i_clk),
      .i_clr(clr),
      .i_pins(o_pins),
      .i_pins_oe_n(o_pins_oe_n),
      .o_level(level),
      .o_hi(hi),
      .o_tog(tog),
      .o_overlap(overlap)
   );

   task test_done;
      if (failures == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      bus.addr <= a;
      bus.wdata <= v;
      bus.wr <= 1'b1;
      @(posedge i_clk);
      bus.wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge i_clk);
      bus.rd <= 1'b0;
      #1 v = o_rdata;
   endtask

   // clear the load's counters, then count n cycles
   task measure(input int n);
      @(posedge i_clk);
      clr <= 1'b1;
      @(posedge i_clk);
      clr <= 1'b0;
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // single pwm on channel 3, high cycles counted over ten periods
   task pwm(input logic [15:0] c, input logic [15:0] a, input logic [15:0] b,
         input logic [31:0] exp);
      wr(mmp_pkg::ADR_CTRL, 32'h0);
      wr(mmp_pkg::ADR_EDGE, {16'h0, a});
      wr(mmp_pkg::ADR_EDGE + 8'h04, {16'h0, b});
      wr(mmp_pkg::ADR_CNT3, 32'h0);
      wr(mmp_pkg::ADR_CTRL, {16'h0, c});
      repeat (12) @(posedge i_clk);
      measure(60);
      chk(32'(hi[0]), exp);
   endtask

   initial begin
      repeat (20000) @(posedge i_clk);
      failures++;
      test_done;
   end

   initial begin
      repeat (8) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(mmp_pkg::ADR_CTRL, d);
      chk(d, 32'h0);
      rd(mmp_pkg::ADR_EDGE, d);
      chk(d, 32'h0000ffff);
      rd(8'h40, d);
      chk(d, 32'h0);
      chk(32'(o_pins_oe_n), 32'h3f);
      wr(mmp_pkg::ADR_EDGE, 32'habcd1234);
      rd(mmp_pkg::ADR_EDGE, d);
      chk(d, 32'h00001234);
      pwm(16'h0405, 16'h0002, 16'h0005, 32'd30);
      chk(32'(o_pins_oe_n.phase1_out), 32'h0);
      pwm(16'h0405, 16'h0007, 16'h0005, 32'd0);
      pwm(16'h0205, 16'h0005, 16'h0007, 32'd60);
      wr(mmp_pkg::ADR_EDGE + 8'h04, 32'h5);
      measure(60);
      chk(32'(hi[0]), 32'd60);
      wr(mmp_pkg::ADR_CTRL, 32'h2000);
      wr(mmp_pkg::ADR_CNT3, 32'h0123);
      rd(mmp_pkg::ADR_CNT4, d);
      chk(d, 32'h00000123);
      wr(mmp_pkg::ADR_EDGE + 8'h08, 32'd1);
      wr(mmp_pkg::ADR_EDGE + 8'h0c, 32'd4);
      wr(mmp_pkg::ADR_CNT4, 32'h0);
      wr(mmp_pkg::ADR_CTRL, 32'h700a);
      repeat (12) @(posedge i_clk);
      measure(60);
      chk(32'(hi[2]), 32'd36);
      chk(32'(o_pins_oe_n.phase2_out), 32'h0);
      rd(mmp_pkg::ADR_CNT3, d);
      chk(d, 32'h0);
      wr(mmp_pkg::ADR_CTRL, 32'h0);
      wr(mmp_pkg::ADR_EDGE, 32'd9);
      wr(mmp_pkg::ADR_EDGE + 8'h04, 32'd3);
      wr(mmp_pkg::ADR_EDGE + 8'h08, 32'd5);
      wr(mmp_pkg::ADR_EDGE + 8'h0c, 32'd7);
      wr(mmp_pkg::ADR_CNT3, 32'h0);
      wr(mmp_pkg::ADR_CTRL, 32'h00d3);
      repeat (20) @(posedge i_clk);
      measure(100);
      chk(32'(o_pins_oe_n), 32'h0);
      for (int k = 0; k < 6; k += 2) begin
         chk(32'(tog[k]), 32'd20);
         chk(32'(hi[k] + hi[k + 1]), 32'd100);
      end
      mx = 0;
      for (int k = 0; k < 12; k++) begin
         @(posedge i_clk);
         rd(mmp_pkg::ADR_CNT3, d);
         if (d > mx) begin
            mx = d;
         end
      end
      chk(32'(mx == 32'd9), 32'h1);
      rd(mmp_pkg::ADR_CNT4, d);
      chk(32'(d > 32'd9), 32'h1);
      wr(mmp_pkg::ADR_CTRL, 32'h0);
      wr(mmp_pkg::ADR_EDGE, 32'd19);
      wr(mmp_pkg::ADR_EDGE + 8'h04, 32'd8);
      wr(mmp_pkg::ADR_EDGE + 8'h08, 32'd10);
      wr(mmp_pkg::ADR_EDGE + 8'h0c, 32'd12);
      wr(mmp_pkg::ADR_BUF, 32'd19);
      wr(mmp_pkg::ADR_BUF + 8'h04, 32'd8);
      wr(mmp_pkg::ADR_BUF + 8'h08, 32'd10);
      wr(mmp_pkg::ADR_BUF + 8'h0c, 32'd30);
      wr(mmp_pkg::ADR_CNT3, 32'd2);
      wr(mmp_pkg::ADR_CNT4, 32'h0);
      wr(mmp_pkg::ADR_STAT, 32'h3f);
      wr(mmp_pkg::ADR_CTRL, 32'h01e1);
      repeat (100) @(posedge i_clk);
      rd(mmp_pkg::ADR_STAT, d);
      chk(32'(d[5]), 32'h1);
      chk(32'(d[0]), 32'h1);
      rd(mmp_pkg::ADR_EDGE + 8'h0c, d);
      chk(d, 32'd30);
      chk(32'(o_pins_oe_n), 32'h0);
      measure(120);
      chk(32'(overlap), 32'h0);
      chk(32'(tog[4] + tog[5]), 32'h0);
      chk(32'(tog[0] != 16'h0), 32'h1);
      mx = 0;
      up = 1'b0;
      dn = 1'b0;
      for (int k = 0; k < 20; k++) begin
         rd(mmp_pkg::ADR_STAT, d);
         dn = dn | d[6];
         up = up | ~d[6];
         rd(mmp_pkg::ADR_CNT3, d);
         if (d > mx) begin
            mx = d;
         end
      end
      chk(32'(up & dn), 32'h1);
      chk(32'(mx <= 32'd20), 32'h1);
      test_done;
   end
endmodule
